// File: logic/flash_erase_write_control.sv
// Purpose: flash erase sequencer, flash store redirection and data-bus memory decoder
// Assumes: sfr and data-bus requests come from the processor on clk_sys_i
// Notes:   the flash array itself, and all RAMs, sit outside this block
//
// Summary of operation
// - mass erase starts only after arm bit set, then 0xAA to command register
// - mass erase is refused unless the emulator port is enabled at command time
// - page erase starts only after page number written, then 0x55 to command
// - erase happens only on exact pattern in required order; a stray command write clears the arm bit and page setup
// - with flash store enable set, external stores also program flash, except while an erase runs
// - an erased flash byte reads back as 0xFF
// - programming only clears bits; changing a programmed byte needs erase first
// - a flash-programming store also writes RAM sharing that address
// - flash spans data addresses 0000-FFFF, 64KB, zero wait states
// - compute-engine data/program RAM take 5 wait states; others take none
// - processor denied compute-engine program RAM while compute engine runs
module flash_erase_write_control (
    input  wire logic        clk_sys_i,
    input  wire logic        reset_n_i,
    // special function register port
    input  wire logic [7:0]  sfr_addr_i,
    input  wire logic        sfr_wr_i,
    input  wire logic        sfr_rd_i,
    input  wire logic [7:0]  sfr_wdata_i,
    output logic      [7:0]  sfr_rdata_o,
    // processor external data bus
    input  wire logic        xreq_i,
    input  wire logic        xwe_i,
    input  wire logic [15:0] xaddr_i,
    input  wire logic [7:0]  xwdata_i,
    output logic             xack_o,
    output logic             xdenied_o,
    output logic      [7:0]  xrdata_o,
    // memory side
    output logic      [15:0] mem_addr_o,
    output logic      [7:0]  mem_wdata_o,
    output logic      [3:0]  ram_sel_o,
    output logic             ram_we_o,
    input  wire logic [7:0]  ram_rdata_i,
    output logic             flash_rd_o,
    output logic             flash_prog_o,
    input  wire logic [7:0]  flash_rdata_i,
    // erase control towards the flash array
    output logic             mass_erase_o,
    output logic             page_erase_o,
    output logic      [6:0]  erase_page_number_o,
    input  wire logic        flash_busy_i,
    // status inputs
    input  wire logic        emulator_port_en_i,
    input  wire logic        ce_running_i
);

    typedef struct packed {
        logic [7:0]                      sfr_rdata;
        logic                            store_en;
        logic                            mass_arm;
        logic [6:0]                      page_num;
        logic                            page_fresh;
        logic [2:0]                      emu_sync;
        logic                            emu_en;
        flash_ctl_pkg::erase_state_type  erase_state;
        logic                            mass_pulse;
        logic                            page_pulse;
        flash_ctl_pkg::bus_state_type    bus_state;
        logic                            denied;
        logic [15:0]                     addr;
        logic [7:0]                      wdata;
        logic [3:0]                      sel;
        logic                            ram_we;
        logic                            flash_rd;
        logic                            flash_prog;
        logic                            ack;
        logic [7:0]                      rdata;
    } ctl_state_type;

    ctl_state_type s_q;
    ctl_state_type s_d;

    logic       timer_load;
    logic [2:0] timer_count;
    logic       timer_expired;

    function automatic logic in_range(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    wait_timer u_wait_timer (
        .clk_sys_i (clk_sys_i),
        .reset_n_i (reset_n_i),
        .load_i    (timer_load),
        .count_i   (timer_count),
        .expired_o (timer_expired)
    );

    always_comb begin
        logic [3:0] region;
        logic       erasing;
        logic       is_ce;
        s_d         = s_q;
        region      = 4'h0;
        erasing     = (s_q.erase_state != flash_ctl_pkg::ERASE_IDLE);
        is_ce       = 1'b0;
        timer_load  = 1'b0;
        timer_count = flash_ctl_pkg::WAIT_FAST;

        // emulator enable comes from a pin: third stage must agree with second
        s_d.emu_sync = {s_q.emu_sync[1:0], emulator_port_en_i};
        if (s_q.emu_sync[1] == s_q.emu_sync[2]) begin
            s_d.emu_en = s_q.emu_sync[2];
        end

        // register reads, one cycle latency
        s_d.sfr_rdata = 8'h00;
        if (sfr_rd_i) begin
            unique case (sfr_addr_i)
                flash_ctl_pkg::SFR_FLASH_CONTROL: begin
                    s_d.sfr_rdata[flash_ctl_pkg::CTL_STORE_EN_BIT] = s_q.store_en;
                    s_d.sfr_rdata[flash_ctl_pkg::CTL_MASS_ARM_BIT] = s_q.mass_arm;
                    s_d.sfr_rdata[flash_ctl_pkg::CTL_BUSY_BIT]     = erasing;
                end
                flash_ctl_pkg::SFR_PAGE_SELECT: begin
                    s_d.sfr_rdata[flash_ctl_pkg::PAGE_LSB +: flash_ctl_pkg::PAGE_W] = s_q.page_num;
                end
                default: begin
                    s_d.sfr_rdata = 8'h00;
                end
            endcase
        end

        // erase sequencer
        s_d.mass_pulse = 1'b0;
        s_d.page_pulse = 1'b0;
        if (sfr_wr_i && sfr_addr_i == flash_ctl_pkg::SFR_FLASH_CONTROL) begin
            s_d.store_en = sfr_wdata_i[flash_ctl_pkg::CTL_STORE_EN_BIT];
            s_d.mass_arm = sfr_wdata_i[flash_ctl_pkg::CTL_MASS_ARM_BIT];
        end
        if (sfr_wr_i && sfr_addr_i == flash_ctl_pkg::SFR_PAGE_SELECT) begin
            s_d.page_num   = sfr_wdata_i[flash_ctl_pkg::PAGE_LSB +: flash_ctl_pkg::PAGE_W];
            s_d.page_fresh = 1'b1;
        end
        unique case (s_q.erase_state)
            flash_ctl_pkg::ERASE_IDLE: begin
                if (sfr_wr_i && sfr_addr_i == flash_ctl_pkg::SFR_ERASE_CMD) begin
                    // a command write while idle consumes the setup, so a retry must redo it
                    s_d.mass_arm   = 1'b0;
                    s_d.page_fresh = 1'b0;
                    if (sfr_wdata_i == flash_ctl_pkg::CMD_MASS_ERASE && s_q.mass_arm
                        && s_q.emu_en) begin
                        s_d.mass_pulse  = 1'b1;
                        s_d.erase_state = flash_ctl_pkg::ERASE_ARM;
                    end else if (sfr_wdata_i == flash_ctl_pkg::CMD_PAGE_ERASE
                                 && s_q.page_fresh) begin
                        s_d.page_pulse  = 1'b1;
                        s_d.erase_state = flash_ctl_pkg::ERASE_ARM;
                    end else begin
                        s_d.erase_state = flash_ctl_pkg::ERASE_IDLE;
                    end
                end
            end
            flash_ctl_pkg::ERASE_ARM: begin
                // commands during an erase are ignored; no queue
                if (flash_busy_i) begin
                    s_d.erase_state = flash_ctl_pkg::ERASE_RUN;
                end
            end
            flash_ctl_pkg::ERASE_RUN: begin
                if (!flash_busy_i) begin
                    s_d.erase_state = flash_ctl_pkg::ERASE_IDLE;
                end
            end
        endcase

        // data-bus decoder
        s_d.ack = 1'b0;
        region[flash_ctl_pkg::SEL_MPU_RAM] = in_range(xaddr_i, flash_ctl_pkg::MPU_RAM_LO, flash_ctl_pkg::MPU_RAM_HI);
        region[flash_ctl_pkg::SEL_CE_DRAM] = in_range(xaddr_i, flash_ctl_pkg::CE_DRAM_LO, flash_ctl_pkg::CE_DRAM_HI);
        region[flash_ctl_pkg::SEL_IO_RAM]  = in_range(xaddr_i, flash_ctl_pkg::IO_RAM_LO, flash_ctl_pkg::IO_RAM_HI);
        region[flash_ctl_pkg::SEL_CE_PRAM] = in_range(xaddr_i, flash_ctl_pkg::CE_PRAM_LO, flash_ctl_pkg::CE_PRAM_HI);
        unique case (s_q.bus_state)
            flash_ctl_pkg::BUS_IDLE: begin
                if (xreq_i) begin
                    s_d.addr   = xaddr_i;
                    s_d.wdata  = xwdata_i;
                    s_d.denied = region[flash_ctl_pkg::SEL_CE_PRAM] && ce_running_i;
                    if (s_d.denied) begin
                        region[flash_ctl_pkg::SEL_CE_PRAM] = 1'b0;
                    end
                    is_ce = region[flash_ctl_pkg::SEL_CE_DRAM] || region[flash_ctl_pkg::SEL_CE_PRAM];
                    // flash overlays the whole space; RAM shares the same addresses
                    s_d.sel        = region;
                    s_d.ram_we     = xwe_i && (region != 4'h0);
                    s_d.flash_prog = xwe_i && s_q.store_en && !erasing;
                    s_d.flash_rd   = !xwe_i && (region == 4'h0) && !s_d.denied;
                    timer_load     = 1'b1;
                    timer_count    = is_ce ? flash_ctl_pkg::WAIT_CE
                                           : flash_ctl_pkg::WAIT_FAST;
                    s_d.bus_state  = flash_ctl_pkg::BUS_ACCESS;
                end
            end
            flash_ctl_pkg::BUS_ACCESS: begin
                if (timer_expired) begin
                    s_d.ack = 1'b1;
                    if (s_q.ram_we || s_q.flash_prog || s_q.denied) begin
                        s_d.rdata = 8'h00;
                    end else if (s_q.flash_rd) begin
                        // a byte under erase has every bit set
                        s_d.rdata = erasing ? flash_ctl_pkg::ERASED_BYTE : flash_rdata_i;
                    end else begin
                        s_d.rdata = ram_rdata_i;
                    end
                    s_d.sel        = 4'h0;
                    s_d.ram_we     = 1'b0;
                    s_d.flash_rd   = 1'b0;
                    s_d.flash_prog = 1'b0;
                    s_d.bus_state  = flash_ctl_pkg::BUS_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q             <= '0;
            s_q.store_en    <= flash_ctl_pkg::FLASH_CONTROL_RST[flash_ctl_pkg::CTL_STORE_EN_BIT];
            s_q.mass_arm    <= flash_ctl_pkg::FLASH_CONTROL_RST[flash_ctl_pkg::CTL_MASS_ARM_BIT];
            s_q.page_num    <= flash_ctl_pkg::PAGE_SELECT_RST[flash_ctl_pkg::PAGE_LSB +: flash_ctl_pkg::PAGE_W];
            s_q.erase_state <= flash_ctl_pkg::ERASE_IDLE;
            s_q.bus_state   <= flash_ctl_pkg::BUS_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign sfr_rdata_o         = s_q.sfr_rdata;
    assign xack_o              = s_q.ack;
    assign xdenied_o           = s_q.denied;
    assign xrdata_o            = s_q.rdata;
    assign mem_addr_o          = s_q.addr;
    assign mem_wdata_o         = s_q.wdata;
    assign ram_sel_o           = s_q.sel;
    assign ram_we_o            = s_q.ram_we;
    assign flash_rd_o          = s_q.flash_rd;
    assign flash_prog_o        = s_q.flash_prog;
    assign mass_erase_o        = s_q.mass_pulse;
    assign page_erase_o        = s_q.page_pulse;
    assign erase_page_number_o = s_q.page_num;

endmodule : flash_erase_write_control

// File: inc/flash_ctl_pkg.sv
// Purpose: shared constants for the flash erase/program controller and data-bus decoder
// Assumes: 8-bit special function register port, 16-bit external data bus
// Notes:   region bounds are inclusive byte addresses
package flash_ctl_pkg;

    // special function register addresses
    localparam logic [7:0]  SFR_ERASE_CMD      = 8'h94;
    localparam logic [7:0]  SFR_FLASH_CONTROL  = 8'hB2;
    localparam logic [7:0]  SFR_PAGE_SELECT    = 8'hB7;

    // flash_control fields
    localparam int          CTL_STORE_EN_BIT   = 0;
    localparam int          CTL_MASS_ARM_BIT   = 1;
    localparam int          CTL_BUSY_BIT       = 7;

    // erase_page_select field: page number in bits 7..1
    localparam int          PAGE_LSB           = 1;
    localparam int          PAGE_W             = 7;

    // reset values
    localparam logic [7:0]  FLASH_CONTROL_RST  = 8'h00;
    localparam logic [7:0]  PAGE_SELECT_RST    = 8'h00;

    // command patterns
    localparam logic [7:0]  CMD_MASS_ERASE     = 8'hAA;
    localparam logic [7:0]  CMD_PAGE_ERASE     = 8'h55;

    // value of an erased flash byte
    localparam logic [7:0]  ERASED_BYTE        = 8'hFF;

    // data-bus regions
    localparam logic [15:0] MPU_RAM_LO         = 16'h0000;
    localparam logic [15:0] MPU_RAM_HI         = 16'h07FF;
    localparam logic [15:0] CE_DRAM_LO         = 16'h1000;
    localparam logic [15:0] CE_DRAM_HI         = 16'h13FF;
    localparam logic [15:0] IO_RAM_LO          = 16'h2000;
    localparam logic [15:0] IO_RAM_HI          = 16'h20FF;
    localparam logic [15:0] CE_PRAM_LO         = 16'h3000;
    localparam logic [15:0] CE_PRAM_HI         = 16'h3FFF;

    // wait states
    localparam logic [2:0]  WAIT_FAST          = 3'h0;
    localparam logic [2:0]  WAIT_CE            = 3'h5;

    // one-hot RAM select vector positions
    localparam int          SEL_MPU_RAM        = 0;
    localparam int          SEL_CE_DRAM        = 1;
    localparam int          SEL_IO_RAM         = 2;
    localparam int          SEL_CE_PRAM        = 3;

    typedef enum logic [2:0] {
        ERASE_IDLE = 3'b001,
        ERASE_ARM  = 3'b010,
        ERASE_RUN  = 3'b100
    } erase_state_type;

    typedef enum logic [1:0] {
        BUS_IDLE   = 2'b01,
        BUS_ACCESS = 2'b10
    } bus_state_type;

endpackage : flash_ctl_pkg

// File: logic/wait_timer.sv
// Purpose: counts the wait states of one data-bus access
// Assumes: load_i is a single-cycle pulse from the same clock domain
// Notes:   expired_o is high whenever the count stands at zero
module wait_timer (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    input  wire logic       load_i,
    input  wire logic [2:0] count_i,
    output logic            expired_o
);

    typedef struct packed {
        logic [2:0] cnt;
    } timer_state_type;

    timer_state_type s_q;
    timer_state_type s_d;

    always_comb begin
        s_d = s_q;
        if (load_i) begin
            s_d.cnt = count_i;
        end else if (s_q.cnt != 3'h0) begin
            s_d.cnt = s_q.cnt - 3'h1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign expired_o = (s_q.cnt == 3'h0);

endmodule : wait_timer

// File: test/flash_erase_write_control_sva.sv
// Purpose: port-level assertions for the flash erase/write controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   wait states are measured from the rise of a RAM select, or from flash_rd_o, to the ack
module flash_erase_write_control_sva (
    input  wire logic       clk_sys_i,
    input  wire logic       reset_n_i,
    input  wire logic [7:0] sfr_addr_i,
    input  wire logic       sfr_wr_i,
    input  wire logic [7:0] sfr_wdata_i,
    input  wire logic       xack_o,
    input  wire logic       xdenied_o,
    input  wire logic [7:0] xrdata_o,
    input  wire logic [3:0] ram_sel_o,
    input  wire logic       ram_we_o,
    input  wire logic       flash_rd_o,
    input  wire logic       mass_erase_o,
    input  wire logic       page_erase_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!reset_n_i);

    property p_mass_cmd;
        mass_erase_o |-> $past(sfr_wr_i && sfr_addr_i == 8'h94 && sfr_wdata_i == 8'hAA);
    endproperty
    a_mass_cmd: assert property (p_mass_cmd) else $error("mass erase without its command");
    property p_page_cmd;
        page_erase_o |-> $past(sfr_wr_i && sfr_addr_i == 8'h94 && sfr_wdata_i == 8'h55);
    endproperty
    a_page_cmd: assert property (p_page_cmd) else $error("page erase without its command");
    property p_erase_pulse;
        (mass_erase_o || page_erase_o) |=> !mass_erase_o && !page_erase_o;
    endproperty
    a_erase_pulse: assert property (p_erase_pulse) else $error("erase strobe too long");
    property p_ce_wait;
        $rose(ram_sel_o[1] || ram_sel_o[3]) |-> !xack_o [*6] ##1 xack_o;
    endproperty
    a_ce_wait: assert property (p_ce_wait) else $error("engine RAM wait count wrong");
    property p_fast_wait;
        $rose(ram_sel_o[0] || ram_sel_o[2]) |=> xack_o;
    endproperty
    a_fast_wait: assert property (p_fast_wait) else $error("fast RAM not zero wait");
    property p_flash_wait;
        flash_rd_o |=> xack_o && !flash_rd_o;
    endproperty
    a_flash_wait: assert property (p_flash_wait) else $error("flash load not zero wait");
    property p_denied;
        (xack_o && xdenied_o) |-> xrdata_o == 8'h00 && $past(ram_sel_o) == 4'h0;
    endproperty
    a_denied: assert property (p_denied) else $error("denied access reached RAM");
    property p_we_sel;
        ram_we_o |-> $onehot(ram_sel_o);
    endproperty
    a_we_sel: assert property (p_we_sel) else $error("RAM store without one select");
endmodule : flash_erase_write_control_sva

// File: test/flash_erase_write_control_tb.sv
// Purpose: self-checking bench for the flash erase/write controller
// Assumes: inputs change 2 ns after the rising edge
// Notes:   latencies are compared against a zero-wait flash load, so pipeline depth is not assumed
module flash_erase_write_control_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys_i = 1'h0, reset_n_i = 1'h0, sfr_wr_i = 1'h0, sfr_rd_i = 1'h0;
    logic        xreq_i = 1'h0, xwe_i = 1'h0, flash_busy_i = 1'h0, emulator_port_en_i = 1'h0, ce_running_i = 1'h0;
    logic [7:0]  sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, xwdata_i = 8'h00, ram_rdata_i = 8'h3C, flash_rdata_i = 8'hA5;
    logic [15:0] xaddr_i = 16'h0000, mem_addr_o;
    logic [7:0]  sfr_rdata_o, xrdata_o, mem_wdata_o, d, rd;
    logic [3:0]  ram_sel_o;
    logic [6:0]  erase_page_number_o, sn;
    logic [1:0]  er;
    logic        xack_o, xdenied_o, ram_we_o, flash_rd_o, flash_prog_o, mass_erase_o, page_erase_o;
    int          err_total = 0, cmp_count = 0, cyc = 0, lat, base;

    flash_erase_write_control flash_erase_write_control_i (.clk_sys_i, .reset_n_i, .sfr_addr_i, .sfr_wr_i,
        .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o, .xreq_i, .xwe_i, .xaddr_i, .xwdata_i, .xack_o, .xdenied_o, .xrdata_o,
        .mem_addr_o, .mem_wdata_o, .ram_sel_o, .ram_we_o, .ram_rdata_i, .flash_rd_o, .flash_prog_o, .flash_rdata_i,
        .mass_erase_o, .page_erase_o, .erase_page_number_o, .flash_busy_i, .emulator_port_en_i, .ce_running_i);

    always #12.5 clk_sys_i = ~clk_sys_i;

    task automatic end_sim;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : end_sim

    // tests take about 140 cycles; a hang is cut well before the run gets long
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            err_total++;
            end_sim();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        cmp_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_i);
        #2;
    endtask : tick

    // one idle cycle after each strobe keeps a driver from re-raising it in the same step
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] w, output logic [1:0] e);
        sfr_addr_i = a;
        sfr_wdata_i = w;
        sfr_wr_i = 1'h1;
        tick(1);
        sfr_wr_i = 1'h0;
        e = {mass_erase_o, page_erase_o};
        tick(1);
    endtask : sfr_wr

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] r);
        sfr_addr_i = a;
        sfr_rd_i = 1'h1;
        tick(1);
        sfr_rd_i = 1'h0;
        r = sfr_rdata_o;
        tick(1);
    endtask : sfr_rd

    // returns {denied, select, ram store, flash program} seen over the access
    task automatic xacc(input logic we, input logic [15:0] a, input logic [7:0] w, output logic [7:0] r,
                        output int n, output logic [6:0] s);
        xwe_i = we;
        xaddr_i = a;
        xwdata_i = w;
        xreq_i = 1'h1;
        tick(1);
        xreq_i = 1'h0;
        n = 0;
        s = 7'h00;
        while (xack_o !== 1'h1 && n < 20) begin
            s[5:0] = s[5:0] | {ram_sel_o, ram_we_o, flash_prog_o};
            tick(1);
            n++;
        end
        r = xrdata_o;
        s[6] = xdenied_o;
        tick(1);
    endtask : xacc

    task automatic busy_run;
        flash_busy_i = 1'h1;
        tick(2);
        sfr_rd(flash_ctl_pkg::SFR_FLASH_CONTROL, d);
        check(16'(d), 16'h0080, "busy status");
        xacc(1'h0, 16'h8000, 8'h00, rd, lat, sn);
        check(16'(rd), 16'(flash_ctl_pkg::ERASED_BYTE), "read during erase");
        // a fresh page number makes the busy command a real candidate, so ignoring it is what is checked
        sfr_wr(8'hB7, 8'h02, er);
        sfr_wr(8'h94, 8'h55, er);
        check(16'(er), 16'h0000, "command while busy");
        flash_busy_i = 1'h0;
        tick(3);
        sfr_rd(flash_ctl_pkg::SFR_FLASH_CONTROL, d);
        check(16'(d), 16'h0000, "idle status");
    endtask : busy_run

    task automatic t_regs;
        sfr_wr(8'h81, 8'hFF, er);
        sfr_wr(8'h94, 8'hFF, er);
        check(16'(er), 16'h0000, "stray command");
        sfr_rd(8'hB2, d);
        check(16'(d), 16'(flash_ctl_pkg::FLASH_CONTROL_RST), "control reset");
        sfr_rd(8'hB7, d);
        check(16'(d), 16'(flash_ctl_pkg::PAGE_SELECT_RST), "page reset");
        sfr_rd(8'h81, d);
        check(16'(d), 16'h0000, "unmapped read");
        $display("test regs done");
    endtask : t_regs

    task automatic t_mass;
        sfr_wr(8'hB2, 8'h02, er);
        sfr_rd(8'hB2, d);
        check(16'(d), 16'h0002, "arm bit");
        sfr_wr(8'h94, 8'hAA, er);
        check(16'(er), 16'h0000, "erase with port off");
        emulator_port_en_i = 1'h1;
        tick(5);
        sfr_wr(8'h94, 8'hAA, er);
        check(16'(er), 16'h0000, "erase unarmed");
        sfr_wr(8'hB2, 8'h02, er);
        sfr_wr(8'h94, 8'h55, er);
        check(16'(er), 16'h0000, "wrong pattern");
        sfr_wr(8'hB2, 8'h02, er);
        sfr_wr(8'h94, 8'hAA, er);
        check(16'(er), 16'h0002, "mass erase");
        busy_run();
        $display("test mass done");
    endtask : t_mass

    task automatic t_page;
        sfr_wr(8'hB7, 8'h0A, er);
        sfr_rd(8'hB7, d);
        check(16'(d), 16'h000A, "page select");
        sfr_wr(8'h94, 8'h33, er);
        sfr_wr(8'h94, 8'h55, er);
        check(16'(er), 16'h0000, "stale page");
        sfr_wr(8'hB7, 8'hFE, er);
        sfr_wr(8'h94, 8'h55, er);
        check(16'(er), 16'h0001, "page erase");
        check(16'(erase_page_number_o), 16'h007F, "page number");
        busy_run();
        $display("test page done");
    endtask : t_page

    task automatic t_map;
        logic [15:0] adr [6] = '{16'h0800, 16'h07FF, 16'h1000, 16'h20FF, 16'h3FFF, 16'hFFFF};
        logic [3:0]  sel [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h8, 4'h0};
        int          ws  [6] = '{0, 0, 5, 0, 5, 0};
        xacc(1'h0, 16'h8000, 8'h00, rd, base, sn);
        check(16'(rd), 16'h00A5, "flash load");
        for (int i = 0; i < 6; i++) begin
            xacc(1'h0, adr[i], 8'h00, rd, lat, sn);
            check(16'(lat), 16'(base + ws[i]), "wait states");
            check(16'(sn[5:2]), 16'(sel[i]), "region select");
            check(16'(rd), (sel[i] == 4'h0) ? 16'h00A5 : 16'h003C, "load data");
        end
        $display("test map done");
    endtask : t_map

    task automatic t_store;
        xacc(1'h1, 16'h2010, 8'h5A, rd, lat, sn);
        check(16'(sn), 16'h0012, "plain store");
        // the pulse width select lives in configuration RAM, outside this block's ports
        // no interrupt source exists on this bench, so the gate is already shut here
        sfr_wr(8'hB2, 8'h01, er);
        // flash stores below stay clear of the configuration settings bytes
        xacc(1'h1, 16'h0400, 8'h12, rd, lat, sn);
        check(16'(sn), 16'h0007, "store both");
        check(mem_addr_o, 16'h0400, "store address");
        check(16'(mem_wdata_o), 16'h0012, "store data");
        xacc(1'h1, 16'h5000, 8'h34, rd, lat, sn);
        check(16'(sn), 16'h0001, "flash store");
        sfr_wr(8'hB2, 8'h00, er);
        xacc(1'h1, 16'h5000, 8'h34, rd, lat, sn);
        check(16'(sn), 16'h0000, "store disabled");
        $display("test store done");
    endtask : t_store

    task automatic t_ce;
        ce_running_i = 1'h1;
        xacc(1'h0, 16'h3000, 8'h00, rd, lat, sn);
        check(16'(sn), 16'h0040, "denied flags");
        check(16'(rd), 16'h0000, "denied data");
        check(16'(lat), 16'(base), "denied wait");
        xacc(1'h0, 16'h1000, 8'h00, rd, lat, sn);
        check(16'(sn), 16'h0008, "data RAM open");
        ce_running_i = 1'h0;
        $display("test engine done");
    endtask : t_ce

    initial begin
        tick(8);
        reset_n_i = 1'h1;
        tick(1);
        t_regs();
        t_mass();
        t_page();
        t_map();
        t_store();
        t_ce();
        end_sim();
    end
endmodule : flash_erase_write_control_tb

bind flash_erase_write_control flash_erase_write_control_sva flash_erase_write_control_sva_i (.clk_sys_i, .reset_n_i,
    .sfr_addr_i, .sfr_wr_i, .sfr_wdata_i, .xack_o, .xdenied_o, .xrdata_o, .ram_sel_o, .ram_we_o, .flash_rd_o,
    .mass_erase_o, .page_erase_o);
